//--- pkg/wwdc_pkg.sv
// shared constants, types and helpers of the windowed watchdog control block
package wwdc_pkg;
   // system clock and counting oscillators
   localparam int unsigned SYS_CLK_HZ = 20_000_000;
   localparam int unsigned LF_OSC_HZ = 31_000;
   localparam int unsigned MF_OSC_HZ = 31_250;
   localparam int unsigned CNT_W = 24;

   ////////////////////////////////////////////////////////////////
   // register word indices
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CLKWIN = 4'h1;
   localparam logic [3:0] ADDR_PSL = 4'h2;
   localparam logic [3:0] ADDR_PSH = 4'h3;
   localparam logic [3:0] ADDR_TMR = 4'h4;
   localparam logic [3:0] ADDR_KICK = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;

   ////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned CTRL0_EN_BIT = 0;
   localparam int unsigned CTRL0_PS_LSB = 1;
   localparam int unsigned CLKWIN_WIN_LSB = 0;
   localparam int unsigned CLKWIN_CS_LSB = 4;
   localparam int unsigned IRQ_TIMEOUT_BIT = 0;
   localparam int unsigned IRQ_WINDOW_BIT = 1;

   ////////////////////////////////////////////////////////////////
   // configuration codes and reset values
   localparam logic [1:0] CFG_EN_SOFT = 2'h1;
   localparam logic [4:0] CFG_PS_UNLOCK = 5'h1f;
   localparam logic [4:0] PS_RESET_UNLOCKED = 5'h0b;
   localparam logic [4:0] PS_MAX_CODE = 5'h12;
   localparam logic [2:0] CFG_CS_UNLOCK = 3'h7;
   localparam logic [2:0] CS_RESET_UNLOCKED = 3'h0;
   localparam logic [2:0] CFG_WIN_UNLOCK = 3'h7;
   localparam logic [2:0] WIN_FULL_OPEN = 3'h7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
   localparam logic [CNT_W-1:0] MIN_RATIO = 24'h00_0020;

   // counting clock sources
   typedef enum logic [2:0] {
      WWDC_SRC_LF = 3'h0,
      WWDC_SRC_MF = 3'h1
   } wwdc_src_t;

   ////////////////////////////////////////////////////////////////
   // terminal count for a prescale code; reserved codes give 1:32
   function automatic logic [CNT_W-1:0] wwdc_last_count(input logic [4:0] ps);
      logic [CNT_W-1:0] ratio;
      ratio = (ps > PS_MAX_CODE) ? MIN_RATIO : (MIN_RATIO << ps);
      return ratio - 24'h00_0001;
   endfunction : wwdc_last_count

   // count at which the window opens: eighths of closed delay
   function automatic logic [CNT_W-1:0] wwdc_open_start(input logic [CNT_W-1:0] last,
                                                        input logic [2:0] win);
      logic [CNT_W-1:0] eighth;
      eighth = (last + 24'h00_0001) >> 3;
      return CNT_W'(eighth * {21'h00_0000, WIN_FULL_OPEN - win});
   endfunction : wwdc_open_start
endpackage : wwdc_pkg

//--- verilog/wwdc_prescaler.sv
// prescale counter that divides the selected watchdog clock
`timescale 1ns/100ps
module wwdc_prescaler
   import wwdc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic run,
   input wire logic restart,
   input wire logic [wwdc_pkg::CNT_W-1:0] last_count,
   output logic [wwdc_pkg::CNT_W-1:0] count_q,
   output logic timeout_q
);
   import wwdc_pkg::*;

   logic [CNT_W-1:0] count_d; // next count
   logic at_last; // terminal count reached
   logic timeout_d; // next time-out pulse

   assign at_last = (count_q >= last_count);
   // stopped or restarted counters sit at zero
   assign count_d = (!run || restart) ? CNT_RESET :
                    (tick && at_last) ? CNT_RESET :
                    tick ? count_q + 24'h00_0001 : count_q;
   assign timeout_d = run && !restart && tick && at_last;

   // counter and pulse flops; reset clears the readout
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_q <= CNT_RESET;
         timeout_q <= 1'b0;
      end else begin
         count_q <= count_d;
         timeout_q <= timeout_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   property p_wrap_at_last;
      @(posedge sys_clk) disable iff (sys_rst)
      (run && !restart && tick && count_q == last_count) |=> (timeout_q && count_q == CNT_RESET);
   endproperty
   a_wrap_at_last: assert property (p_wrap_at_last) else $error("no time-out at terminal count");

   property p_stop_clears;
      @(posedge sys_clk) disable iff (sys_rst)
      !run |=> (count_q == CNT_RESET && !timeout_q);
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not cleared");
endmodule : wwdc_prescaler

//--- verilog/wwdc_top.sv
// windowed watchdog control and status registers with time-out counter
`timescale 1ns/100ps
// What this block does
// - prescale codes 0..6 give 1:32 up to 1:2048
// - soft enable counts only when config is 01
// - intervals assume the 31 kHz slow oscillator
// - prescale resets to 01011 or config value
// - prescale writable only when config is 11111
// - clock select 000 slow, 001 medium, rest reserved
// - window code sets eighths of closed delay
// - clock select resets to 000 when unlocked
// - window resets from config window default
// - clock select locked unless config is 111
// - window locked unless config is 111
// - prescale counter readable, zero after reset
// - clock window bits 7 and 3 read zero
// - timer register holds count 21:16 and armed
module wwdc_top
   import wwdc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic lf_osc_in,
   input wire logic mf_osc_in,
   input wire logic [1:0] config_enable_field,
   input wire logic [4:0] config_prescale_default,
   input wire logic [2:0] config_clock_default,
   input wire logic [2:0] config_window_default,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   output logic wdt_reset_req,
   output logic window_open
);
   import wwdc_pkg::*;

   ////////////////////////////////////////////////////////////////
   // oscillator synchronisers
   logic lf_s1_q; // first stage, slow oscillator
   logic lf_s2_q; // second stage
   logic lf_s3_q; // edge history
   logic mf_s1_q; // first stage, medium oscillator
   logic mf_s2_q; // second stage
   logic mf_s3_q; // edge history
   logic lf_tick; // rising edge, slow oscillator
   logic mf_tick; // rising edge, medium oscillator

   // two flops per pin, a third for edge detection
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lf_s1_q <= 1'b0;
         lf_s2_q <= 1'b0;
         lf_s3_q <= 1'b0;
         mf_s1_q <= 1'b0;
         mf_s2_q <= 1'b0;
         mf_s3_q <= 1'b0;
      end else begin
         lf_s1_q <= lf_osc_in;
         lf_s2_q <= lf_s1_q;
         lf_s3_q <= lf_s2_q;
         mf_s1_q <= mf_osc_in;
         mf_s2_q <= mf_s1_q;
         mf_s3_q <= mf_s2_q;
      end
   end

   assign lf_tick = lf_s2_q && !lf_s3_q;
   assign mf_tick = mf_s2_q && !mf_s3_q;

   ////////////////////////////////////////////////////////////////
   // software registers
   logic [4:0] ps_q; // time-out prescale select
   logic [4:0] ps_d;
   logic soft_en_q; // soft enable bit
   logic soft_en_d;
   logic [2:0] cs_q; // clock source select
   logic [2:0] cs_d;
   logic [2:0] win_q; // window select
   logic [2:0] win_d;
   logic [1:0] irq_stat_q; // sticky event bits
   logic [1:0] irq_stat_d;
   logic [1:0] irq_en_q; // interrupt enables
   logic [1:0] irq_en_d;
   logic [7:0] rdata_q; // read data, one cycle after strobe
   logic [7:0] rdata_d;
   logic reset_req_q; // reset request pulse
   logic reset_req_d;

   // decoded strobes
   logic wr_ctrl0;
   logic wr_clkwin;
   logic wr_kick;
   logic wr_irq_en;
   logic wr_irq_clr;
   logic ps_unlocked; // prescale field writable
   logic cs_unlocked; // clock field writable
   logic win_unlocked; // window field writable

   assign wr_ctrl0 = reg_wr && (reg_addr == ADDR_CTRL0);
   assign wr_clkwin = reg_wr && (reg_addr == ADDR_CLKWIN);
   assign wr_kick = reg_wr && (reg_addr == ADDR_KICK);
   assign wr_irq_en = reg_wr && (reg_addr == ADDR_IRQ_EN);
   assign wr_irq_clr = reg_wr && (reg_addr == ADDR_IRQ_CLR);
   assign ps_unlocked = (config_prescale_default == CFG_PS_UNLOCK);
   assign cs_unlocked = (config_clock_default == CFG_CS_UNLOCK);
   assign win_unlocked = (config_window_default == CFG_WIN_UNLOCK);

   // locked fields ignore software writes
   assign ps_d = (wr_ctrl0 && ps_unlocked) ? reg_wdata[CTRL0_PS_LSB +: 5] : ps_q;
   assign soft_en_d = wr_ctrl0 ? reg_wdata[CTRL0_EN_BIT] : soft_en_q;
   assign cs_d = (wr_clkwin && cs_unlocked) ? reg_wdata[CLKWIN_CS_LSB +: 3] : cs_q;
   assign win_d = (wr_clkwin && win_unlocked) ? reg_wdata[CLKWIN_WIN_LSB +: 3] : win_q;
   assign irq_en_d = wr_irq_en ? reg_wdata[1:0] : irq_en_q;

   ////////////////////////////////////////////////////////////////
   // watchdog core
   logic armed; // watchdog counting
   logic tick; // selected clock edge
   logic [CNT_W-1:0] last_count; // terminal count
   logic [CNT_W-1:0] open_start; // first count inside window
   logic [CNT_W-1:0] cnt; // prescale counter value
   logic timeout; // time-out pulse
   logic kick_ok; // restart inside window
   logic violation; // restart before window opened
   logic [1:0] events; // this cycle's events

   // config 01 hands control to software; 1x always on, 00 off
   assign armed = (config_enable_field == CFG_EN_SOFT) ? soft_en_q :
                  config_enable_field[1];
   // slow source is the nominal reference for all intervals
   assign tick = (cs_q == WWDC_SRC_LF) ? lf_tick :
                 (cs_q == WWDC_SRC_MF) ? mf_tick : 1'b0;
   assign last_count = wwdc_last_count(ps_q);
   assign open_start = wwdc_open_start(last_count, win_q);
   assign window_open = armed && (cnt >= open_start);
   assign kick_ok = wr_kick && armed && window_open;
   assign violation = wr_kick && armed && !window_open;

   wwdc_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .run(armed),
      .restart(kick_ok || violation),
      .last_count(last_count),
      .count_q(cnt),
      .timeout_q(timeout)
   );

   assign reset_req_d = timeout || violation;

   ////////////////////////////////////////////////////////////////
   // interrupts: set wins over clear
   assign events[IRQ_TIMEOUT_BIT] = timeout;
   assign events[IRQ_WINDOW_BIT] = violation;
   assign irq_stat_d = (irq_stat_q & ~(wr_irq_clr ? reg_wdata[1:0] : 2'h0)) | events;

   ////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   logic [7:0] rd_mux;
   logic [7:0] rd_clkwin;
   logic [7:0] rd_tmr;

   assign rd_clkwin = {1'h0, cs_q, 1'h0, win_q};
   assign rd_tmr = {1'h0, cnt[21:18], armed, cnt[17:16]};
   always_comb begin
      unique case (reg_addr)
         ADDR_CTRL0: rd_mux = {2'h0, ps_q, soft_en_q};
         ADDR_CLKWIN: rd_mux = rd_clkwin;
         ADDR_PSL: rd_mux = cnt[7:0];
         ADDR_PSH: rd_mux = cnt[15:8];
         ADDR_TMR: rd_mux = rd_tmr;
         ADDR_KICK: rd_mux = {7'h00, window_open};
         ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
         ADDR_IRQ_EN: rd_mux = {6'h00, irq_en_q};
         default: rd_mux = REG_RESET;
      endcase
   end
   assign rdata_d = reg_rd ? rd_mux : REG_RESET;

   // register flops; reset loads config-derived values
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ps_q <= ps_unlocked ? PS_RESET_UNLOCKED : config_prescale_default;
         cs_q <= cs_unlocked ? CS_RESET_UNLOCKED : config_clock_default;
         win_q <= config_window_default;
         soft_en_q <= 1'b0;
         irq_stat_q <= IRQ_RESET;
         irq_en_q <= IRQ_RESET;
         rdata_q <= REG_RESET;
         reset_req_q <= 1'b0;
      end else begin
         ps_q <= ps_d;
         cs_q <= cs_d;
         win_q <= win_d;
         soft_en_q <= soft_en_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         rdata_q <= rdata_d;
         reset_req_q <= reset_req_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq = |(irq_stat_q & irq_en_q);
   assign wdt_reset_req = reset_req_q;

   ////////////////////////////////////////////////////////////////
   // checks
   sequence s_wr_ctrl0_locked;
      wr_ctrl0 && !ps_unlocked;
   endsequence

   sequence s_wr_clkwin;
      wr_clkwin;
   endsequence

   property p_ps_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      s_wr_ctrl0_locked |=> $stable(ps_q);
   endproperty
   a_ps_lock: assert property (p_ps_lock) else $error("locked prescale changed");

   property p_ps_reset;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (ps_q == (ps_unlocked ? PS_RESET_UNLOCKED : config_prescale_default));
   endproperty
   a_ps_reset: assert property (p_ps_reset) else $error("bad prescale reset value");

   property p_soft_en;
      @(posedge sys_clk) disable iff (sys_rst)
      (wr_ctrl0 && config_enable_field == CFG_EN_SOFT) |=> (armed == $past(reg_wdata[0]));
   endproperty
   a_soft_en: assert property (p_soft_en) else $error("soft enable not obeyed");

   property p_cs_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_wr_clkwin and !cs_unlocked) |=> $stable(cs_q);
   endproperty
   a_cs_lock: assert property (p_cs_lock) else $error("locked clock select changed");

   property p_win_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_wr_clkwin and !win_unlocked) |=> $stable(win_q);
   endproperty
   a_win_lock: assert property (p_win_lock) else $error("locked window changed");

   property p_cfg_reset;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (win_q == config_window_default &&
                          (!cs_unlocked || cs_q == CS_RESET_UNLOCKED) && cnt == CNT_RESET);
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("bad clock, window or count reset");

   property p_zero_bits;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_CLKWIN) |=> (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0);
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bits set");

   property p_tmr_map;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_TMR) |=> (reg_rdata[1:0] == $past(cnt[17:16]) &&
                                            reg_rdata[2] == $past(armed));
   endproperty
   a_tmr_map: assert property (p_tmr_map) else $error("timer register layout wrong");

   property p_reserved_src;
      @(posedge sys_clk) disable iff (sys_rst)
      (cs_q > WWDC_SRC_MF && armed && !wr_kick) |=> $stable(cnt);
   endproperty
   a_reserved_src: assert property (p_reserved_src) else $error("reserved source counted");

   // an early kick restarts, requests reset and latches the window flag
   property p_early_kick;
      @(posedge sys_clk) disable iff (sys_rst)
      violation |=> (wdt_reset_req && cnt == CNT_RESET && irq_stat_q[IRQ_WINDOW_BIT]);
   endproperty
   a_early_kick: assert property (p_early_kick) else $error("early kick not handled");

   // a kick inside the window only restarts the count
   property p_open_kick;
      @(posedge sys_clk) disable iff (sys_rst)
      kick_ok |=> (cnt == CNT_RESET);
   endproperty
   a_open_kick: assert property (p_open_kick) else $error("kick in window did not restart");

   // terminal count requests reset and latches the time-out flag
   property p_timeout_flag;
      @(posedge sys_clk) disable iff (sys_rst)
      timeout |=> (wdt_reset_req && irq_stat_q[IRQ_TIMEOUT_BIT]);
   endproperty
   a_timeout_flag: assert property (p_timeout_flag) else $error("time-out not reported");

   // low byte readout follows the live count
   property p_psl_read;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_PSL) |=> (reg_rdata == $past(cnt[7:0]));
   endproperty
   a_psl_read: assert property (p_psl_read) else $error("low count byte wrong");

   // high byte readout follows the live count
   property p_psh_read;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_PSH) |=> (reg_rdata == $past(cnt[15:8]));
   endproperty
   a_psh_read: assert property (p_psh_read) else $error("high count byte wrong");
endmodule : wwdc_top

//--- bench/tb_wwdc_top.sv
// self-checking testbench of the windowed watchdog control block
`timescale 1ns/100ps
module tb_wwdc_top;
   import wwdc_pkg::*;
   localparam int CEIL = 90000; // run ceiling in clock cycles
   localparam int OSC_P = 4; // bench oscillator period in clock cycles
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic lf_osc_in = 1'b0;
   logic mf_osc_in = 1'b0;
   logic [1:0] cfg_en = 2'h2;
   logic [4:0] cfg_ps = 5'h1f;
   logic [2:0] cfg_cs = 3'h7;
   logic [2:0] cfg_win = 3'h7;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic irq;
   logic wdt_reset_req;
   logic window_open;
   logic lf_run = 1'b0; // oscillators stand still unless enabled
   logic mf_run = 1'b0;
   logic [1:0] osc_div = 2'h0;
   logic [7:0] seed = 8'h59; // lfsr state, starts at 89
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc_total = 0;
   ////////////////////////////////////////////////////////////////
   wwdc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .lf_osc_in(lf_osc_in), .mf_osc_in(mf_osc_in),
      .config_enable_field(cfg_en), .config_prescale_default(cfg_ps), .config_clock_default(cfg_cs),
      .config_window_default(cfg_win), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .wdt_reset_req(wdt_reset_req),
      .window_open(window_open));
   // clock: 50 ns period
   always #25 sys_clk = ~sys_clk;
   // scaled stand-ins for the slow and medium oscillators
   always @(posedge sys_clk) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div[0]) begin
         if (lf_run) lf_osc_in <= ~lf_osc_in;
         if (mf_run) mf_osc_in <= ~mf_osc_in;
      end
   end
   // hang guard
   always @(posedge sys_clk) begin
      cyc_total <= cyc_total + 1;
      if (cyc_total == CEIL) begin
         n_mismatch++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   // pseudo random byte
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   // expected prescale after reset
   function automatic logic [4:0] ps_rst(input logic [4:0] c);
      return (c == 5'h1f) ? 5'h0b : c;
   endfunction : ps_rst
   // expected clock select after reset
   function automatic logic [2:0] cs_rst(input logic [2:0] c);
      return (c == 3'h7) ? 3'h0 : c;
   endfunction : cs_rst
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(what, d & mask, exp);
   endtask : rd_chk
   // cycles until the next reset request pulse, bounded
   task automatic wait_req(output int cyc);
      cyc = 0;
      do begin
         @(posedge sys_clk);
         #1 cyc++;
      end while (wdt_reset_req !== 1'b1 && cyc < 20000);
   endtask : wait_req
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      int cyc;
      do_reset();
      // reset values and locks over random locked and unlocked configurations
      for (int i = 0; i < 6; i++) begin
         seed = lfsr_next(seed);
         @(posedge sys_clk);
         cfg_ps <= (i[0]) ? 5'h1f : ((seed[4:0] == 5'h1f) ? 5'h03 : seed[4:0]);
         cfg_cs <= (i[0]) ? 3'h7 : {1'b0, seed[5:4]};
         cfg_win <= (i[0]) ? 3'h7 : {1'b0, seed[7:6]};
         do_reset();
         rd_chk("ctrl0 reset", ADDR_CTRL0, 8'hff, {2'h0, ps_rst(cfg_ps), 1'b0});
         rd_chk("clkwin reset", ADDR_CLKWIN, 8'hff, {1'b0, cs_rst(cfg_cs), 1'b0, cfg_win});
         rd_chk("psl reset", ADDR_PSL, 8'hff, 8'h00);
         rd_chk("psh reset", ADDR_PSH, 8'hff, 8'h00);
         rd_chk("tmr reset", ADDR_TMR, 8'hfb, 8'h00);
         seed = lfsr_next(seed);
         wr(ADDR_CTRL0, seed);
         rd_chk("ctrl0 write", ADDR_CTRL0, 8'hff, {2'h0, i[0] ? seed[5:1] : ps_rst(cfg_ps), seed[0]});
         wr(ADDR_CLKWIN, ~seed);
         rd_chk("clkwin write", ADDR_CLKWIN, 8'hff,
            i[0] ? (~seed & 8'h77) : {1'b0, cs_rst(cfg_cs), 1'b0, cfg_win});
         wr(ADDR_PSL, seed);
         rd_chk("psl read only", ADDR_PSL, 8'hff, 8'h00);
         rd_chk("unmapped", 4'hc, 8'hff, 8'h00);
      end
      // soft enable against each enable configuration
      @(posedge sys_clk);
      cfg_ps <= 5'h1f;
      cfg_cs <= 3'h7;
      cfg_win <= 3'h7;
      for (int e = 0; e < 4; e++) begin
         @(posedge sys_clk);
         cfg_en <= e[1:0];
         do_reset();
         rd_chk("armed after reset", ADDR_TMR, 8'h04, {5'h00, e[1], 2'h0});
         wr(ADDR_CTRL0, 8'h01);
         rd_chk("armed soft on", ADDR_TMR, 8'h04, {5'h00, e[1] | e[0], 2'h0});
         wr(ADDR_CTRL0, 8'h00);
         rd_chk("armed soft off", ADDR_TMR, 8'h04, {5'h00, e[1], 2'h0});
      end
      // time-out interval for prescale codes 0 to 6
      @(posedge sys_clk);
      cfg_en <= 2'h1;
      do_reset();
      lf_run <= 1'b1;
      for (int c = 0; c < 7; c++) begin
         wr(ADDR_CTRL0, {2'h0, c[4:0], 1'b1});
         wait_req(cyc);
         wait_req(cyc);
         check("timeout interval", cyc, (32 << c) * OSC_P);
      end
      // sticky status, enable mask and clear
      lf_run = 1'b0;
      repeat (8) @(posedge sys_clk);
      rd_chk("status timeout", ADDR_IRQ_STAT, 8'h01, 8'h01);
      check("irq masked", irq, 1'b0);
      wr(ADDR_IRQ_EN, 8'h01);
      #1 check("irq enabled", irq, 1'b1);
      wr(ADDR_IRQ_CLR, 8'h03);
      #1 check("irq cleared", irq, 1'b0);
      rd_chk("status cleared", ADDR_IRQ_STAT, 8'h03, 8'h00);
      // window: a kick right after a restart is early unless fully open
      wr(ADDR_CTRL0, 8'h01);
      lf_run <= 1'b1;
      for (int w = 0; w < 8; w++) begin
         wr(ADDR_CLKWIN, {5'h00, w[2:0]});
         wr(ADDR_KICK, 8'h00);
         wr(ADDR_IRQ_CLR, 8'h03);
         wr(ADDR_KICK, 8'h00);
         #1 check("window open", window_open, w == 7);
         rd_chk("window violation", ADDR_IRQ_STAT, 8'h02, {6'h00, w != 7, 1'b0});
      end
      // medium oscillator counts, reserved sources hold the count
      lf_run = 1'b0;
      mf_run = 1'b1;
      wr(ADDR_CLKWIN, 8'h17);
      wait_req(cyc);
      wait_req(cyc);
      check("medium interval", cyc, 32 * OSC_P);
      for (int s = 2; s < 8; s++) begin
         wr(ADDR_CLKWIN, {1'b0, s[2:0], 4'h7});
         rd(ADDR_PSL, d);
         repeat (40) @(posedge sys_clk);
         rd_chk("reserved source", ADDR_PSL, 8'hff, d);
      end
      finish_test();
   end
endmodule : tb_wwdc_top
